// >>> hw/mbs_exec.sv
// Purpose: Executes multiply, jump, call, return, compare, skip and branch.
// Assumes: Program memory answers imem_data for imem_addr in the same cycle.
// Notes:   Other opcodes are passed out on foreign_op and take one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mbs_map.svh"
module mbs_exec #(
   parameter int PC_W    = 22,
   parameter int STACK_D = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output var  logic             pready,
   output var  logic [31:0]      prdata,
   output var  logic             pslverr,
   input  wire logic [15:0]      imem_data,
   output var  logic [PC_W-1:0]  imem_addr,
   input  wire logic [255:0]     io_low_bits,
   output var  logic             foreign_op,
   output var  logic [15:0]      foreign_word
);
   localparam int SP_W = $clog2(STACK_D);
   localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);
   localparam logic [PC_W-1:0] PC_TWO = PC_W'(2);

   typedef struct packed {
      mbs_pkg::mbs_state_t           st;
      logic                          run;
      logic [PC_W-1:0]               pc;
      logic [7:0]                    flags;
      logic [7:0]                    ext_hi;
      logic [SP_W-1:0]               sp;
      logic [STACK_D-1:0][PC_W-1:0]  stack;
      logic [31:0][7:0]              gpr;
      logic [2:0]                    wait_cnt;
      logic [5:0]                    abs_hi;
      logic                          abs_call;
      logic                          pready;
      logic                          pslverr;
      logic [31:0]                   prdata;
      logic                          foreign;
      logic [15:0]                   foreign_word;
   } mbs_regs_t;

   mbs_regs_t        s_q;
   mbs_regs_t        s_d;
   logic [7:0]       mul_a;
   logic [7:0]       mul_b;
   logic             mul_as;
   logic             mul_bs;
   logic             mul_frac;
   logic [15:0]      mul_res;
   logic             mul_c;
   logic             mul_z;

   // ========================================================================
   // Compare flag evaluation
   function automatic logic [7:0] cmp_flags(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic       cin,
                                            input logic       zchain,
                                            input logic [7:0] f);
      logic [7:0] r;
      logic [7:0] o;
      r = a - b - {7'h00, cin};
      o = f;
      o[`MBS_FL_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      o[`MBS_FL_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o[`MBS_FL_N] = r[7];
      o[`MBS_FL_S] = r[7] ^ o[`MBS_FL_V];
      // With carry-in, zero can only stay set, so multi-byte compares chain
      o[`MBS_FL_Z] = (r == 8'h00) & (~zchain | f[`MBS_FL_Z]);
      o[`MBS_FL_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      return o;
   endfunction

   function automatic logic two_word(input logic [15:0] w);
      return ((w[15:9] == 7'b1001010) && (w[3:2] == 2'b11)) ||
             ((w[15:10] == 6'b100100) && (w[3:0] == 4'h0));
   endfunction

   // ========================================================================
   // Multiplier operand selection
   always_comb begin
      mul_a    = s_q.gpr[imem_data[8:4]];
      mul_b    = s_q.gpr[{imem_data[9], imem_data[3:0]}];
      mul_as   = 1'b0;
      mul_bs   = 1'b0;
      mul_frac = 1'b0;
      if (imem_data[15:8] == 8'h02) begin
         mul_a  = s_q.gpr[{1'b1, imem_data[7:4]}];
         mul_b  = s_q.gpr[{1'b1, imem_data[3:0]}];
         mul_as = 1'b1;
         mul_bs = 1'b1;
      end else if (imem_data[15:8] == 8'h03) begin
         mul_a    = s_q.gpr[{2'b10, imem_data[6:4]}];
         mul_b    = s_q.gpr[{2'b10, imem_data[2:0]}];
         mul_as   = imem_data[7] | ~imem_data[3];
         mul_bs   = imem_data[7] & ~imem_data[3];
         mul_frac = imem_data[7] | imem_data[3];
      end
   end

   mbs_mul u_mul (
      .op_a     (mul_a),
      .op_b     (mul_b),
      .a_signed (mul_as),
      .b_signed (mul_bs),
      .frac     (mul_frac),
      .result   (mul_res),
      .carry    (mul_c),
      .zero     (mul_z)
   );

   // ========================================================================
   // Next state
   always_comb begin
      logic [15:0]      w;
      logic [7:0]       rd_v;
      logic [7:0]       rr_v;
      logic [PC_W-1:0]  k7;
      logic [PC_W-1:0]  k12;
      logic [PC_W-1:0]  zptr;
      logic [PC_W-1:0]  ezptr;
      logic [SP_W-1:0]  sp_m1;
      logic             err;
      logic [31:0]      rd;
      w     = imem_data;
      rd_v  = s_q.gpr[w[8:4]];
      rr_v  = s_q.gpr[{w[9], w[3:0]}];
      k7    = {{(PC_W-7){w[9]}}, w[9:3]};
      k12   = {{(PC_W-12){w[11]}}, w[11:0]};
      zptr  = PC_W'({s_q.gpr[31], s_q.gpr[30]});
      ezptr = PC_W'({s_q.ext_hi, s_q.gpr[31], s_q.gpr[30]});
      sp_m1 = s_q.sp - SP_W'(1);
      err   = 1'b0;
      rd    = 32'h0000_0000;
      s_d   = s_q;
      s_d.foreign = 1'b0;

      // Sequencer: flags are written only by the multiply and compare arms
      unique case (s_q.st)
         mbs_pkg::mbs_st_idle: begin
            if (s_q.run) begin
               s_d.st = mbs_pkg::mbs_st_exec;
            end
         end
         mbs_pkg::mbs_st_exec: begin
            if (!s_q.run) begin
               s_d.st = mbs_pkg::mbs_st_idle;
            end else begin
               s_d.pc = s_q.pc + PC_ONE;
               casez (w)
                  `MBS_OP_MUL, `MBS_OP_PRODUCT_SIGNED, `MBS_OP_PRODUCT_MIXED_SIGN_GRP: begin
                     s_d.gpr[1]              = mul_res[15:8];
                     s_d.gpr[0]              = mul_res[7:0];
                     s_d.flags[`MBS_FL_C]    = mul_c;
                     s_d.flags[`MBS_FL_Z]    = mul_z;
                     s_d.wait_cnt            = 3'(`MBS_CYC_MUL - 1);
                     s_d.st                  = mbs_pkg::mbs_st_wait;
                  end
                  `MBS_OP_RELATIVE_GOTO, `MBS_OP_RELATIVE_SUBROUTINE_INVOKE: begin
                     s_d.pc = s_q.pc + k12 + PC_ONE;
                     s_d.st = mbs_pkg::mbs_st_wait;
                     if (w[12]) begin
                        s_d.stack[s_q.sp] = s_q.pc + PC_ONE;
                        s_d.sp            = s_q.sp + SP_W'(1);
                        s_d.wait_cnt      = 3'(`MBS_CYC_INVOKE - 1);
                     end else begin
                        s_d.wait_cnt      = 3'(`MBS_CYC_GOTO - 1);
                     end
                  end
                  `MBS_OP_POINTER_GOTO, `MBS_OP_EXTENDED_POINTER_GOTO, `MBS_OP_POINTER_SUBROUTINE_INVOKE, `MBS_OP_EXTENDED_POINTER_INVOKE: begin
                     s_d.pc = w[4] ? ezptr : zptr;
                     s_d.st = mbs_pkg::mbs_st_wait;
                     if (w[8]) begin
                        s_d.stack[s_q.sp] = s_q.pc + PC_ONE;
                        s_d.sp            = s_q.sp + SP_W'(1);
                        s_d.wait_cnt      = 3'(`MBS_CYC_INVOKE - 1);
                     end else begin
                        s_d.wait_cnt      = 3'(`MBS_CYC_GOTO - 1);
                     end
                  end
                  `MBS_OP_JMP, `MBS_OP_CALL: begin
                     s_d.abs_hi   = {w[8:4], w[0]};
                     s_d.abs_call = w[1];
                     s_d.st       = mbs_pkg::mbs_st_word2;
                  end
                  `MBS_OP_RET, `MBS_OP_INTERRUPT_EXIT: begin
                     // Both exits only pop; the flags are left as they are
                     s_d.pc       = s_q.stack[sp_m1];
                     s_d.sp       = sp_m1;
                     s_d.wait_cnt = 3'(`MBS_CYC_EXIT - 1);
                     s_d.st       = mbs_pkg::mbs_st_wait;
                  end
                  `MBS_OP_EQUAL_SKIP_COMPARE: begin
                     if (rd_v == rr_v) begin
                        s_d.st = mbs_pkg::mbs_st_skipchk;
                     end
                  end
                  `MBS_OP_CP, `MBS_OP_CPC: begin
                     s_d.flags = cmp_flags(rd_v, rr_v,
                                           ~w[12] & s_q.flags[`MBS_FL_C],
                                           ~w[12], s_q.flags);
                  end
                  `MBS_OP_CPI: begin
                     s_d.flags = cmp_flags(s_q.gpr[{1'b1, w[7:4]}],
                                           {w[11:8], w[3:0]}, 1'b0, 1'b0,
                                           s_q.flags);
                  end
                  `MBS_OP_SKIP_REG: begin
                     if (s_q.gpr[w[8:4]][w[2:0]] == w[9]) begin
                        s_d.st = mbs_pkg::mbs_st_skipchk;
                     end
                  end
                  `MBS_OP_SKIP_IO: begin
                     // A five-bit port field reaches only the bit-addressable range
                     if (io_low_bits[{w[7:3], w[2:0]}] == w[9]) begin
                        s_d.st = mbs_pkg::mbs_st_skipchk;
                     end
                  end
                  `MBS_OP_BRANCH: begin
                     // Named branches are this test with fixed s: Z, C, N, S, H, T, V
                     if (s_q.flags[w[2:0]] == ~w[10]) begin
                        s_d.pc       = s_q.pc + k7 + PC_ONE;
                        s_d.wait_cnt = 3'(`MBS_CYC_BR_TAKEN - 1);
                        s_d.st       = mbs_pkg::mbs_st_wait;
                     end
                  end
                  default: begin
                     s_d.foreign      = 1'b1;
                     s_d.foreign_word = w;
                  end
               endcase
            end
         end
         mbs_pkg::mbs_st_word2: begin
            s_d.pc = PC_W'({s_q.abs_hi, w});
            s_d.st = mbs_pkg::mbs_st_wait;
            if (s_q.abs_call) begin
               s_d.stack[s_q.sp] = s_q.pc + PC_ONE;
               s_d.sp            = s_q.sp + SP_W'(1);
               s_d.wait_cnt      = 3'(`MBS_CYC_INVOKE_ABS - 2);
            end else begin
               s_d.wait_cnt      = 3'(`MBS_CYC_GOTO_ABS - 2);
            end
         end
         mbs_pkg::mbs_st_skipchk: begin
            // The skipped word is read here so its length sets the cost
            if (two_word(w)) begin
               s_d.pc       = s_q.pc + PC_TWO;
               s_d.wait_cnt = 3'd1;
               s_d.st       = mbs_pkg::mbs_st_wait;
            end else begin
               s_d.pc = s_q.pc + PC_ONE;
               s_d.st = mbs_pkg::mbs_st_exec;
            end
         end
         mbs_pkg::mbs_st_wait: begin
            s_d.wait_cnt = s_q.wait_cnt - 3'd1;
            if (s_q.wait_cnt == 3'd1) begin
               s_d.st = mbs_pkg::mbs_st_exec;
            end
         end
      endcase

      // APB: answer prepared in the setup cycle, one access cycle always
      s_d.pready = psel & ~penable;
      // The error flag stands only beside pready, so a stale error never lingers
      s_d.pslverr = 1'b0;
      if (psel && !penable) begin
         err = (paddr[1:0] != 2'b00);
         if (paddr[11:7] == `MBS_GPR_WIN) begin
            rd = {24'h000000, s_q.gpr[paddr[6:2]]};
         end else begin
            unique case (paddr)
               `MBS_OFS_CTRL:  rd = {31'h0000_0000, s_q.run};
               `MBS_OFS_STAT:  rd = {{(23-SP_W){1'b0}}, s_q.sp, 8'h00,
                                     s_q.st != mbs_pkg::mbs_st_idle};
               `MBS_OFS_PC:    rd = 32'(s_q.pc);
               `MBS_OFS_FLAGS: rd = {24'h000000, s_q.flags};
               `MBS_OFS_EXTHI: rd = {24'h000000, s_q.ext_hi};
               default:        err = 1'b1;
            endcase
         end
         // State other than the run bit is writable only while halted
         if (pwrite && paddr != `MBS_OFS_CTRL &&
             (s_q.run || s_q.st != mbs_pkg::mbs_st_idle)) begin
            err = 1'b1;
         end
         if (pwrite && paddr == `MBS_OFS_STAT) begin
            err = 1'b1;
         end
         s_d.prdata  = pwrite ? 32'h0000_0000 : rd;
         s_d.pslverr = err;
      end
      if (psel && penable && s_q.pready && pwrite && !s_q.pslverr) begin
         if (paddr[11:7] == `MBS_GPR_WIN) begin
            s_d.gpr[paddr[6:2]] = pwdata[7:0];
         end else if (paddr == `MBS_OFS_CTRL) begin
            s_d.run = pwdata[`MBS_CTRL_RUN];
         end else if (paddr == `MBS_OFS_PC) begin
            s_d.pc = pwdata[PC_W-1:0];
         end else if (paddr == `MBS_OFS_FLAGS) begin
            s_d.flags = pwdata[7:0];
         end else if (paddr == `MBS_OFS_EXTHI) begin
            s_d.ext_hi = pwdata[7:0];
         end
      end
   end

   // ========================================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q        <= '0;
         s_q.st     <= mbs_pkg::mbs_st_idle;
         s_q.pc     <= PC_W'(`MBS_RST_PC);
         s_q.flags  <= `MBS_RST_FLAGS;
         s_q.ext_hi <= `MBS_RST_EXTHI;
      end else begin
         s_q <= s_d;
      end
   end

   assign pready       = s_q.pready;
   assign prdata       = s_q.prdata;
   assign pslverr      = s_q.pslverr;
   assign imem_addr    = s_q.pc;
   assign foreign_op   = s_q.foreign;
   assign foreign_word = s_q.foreign_word;
endmodule
`default_nettype wire

// >>> hw/mbs_map.svh
// Purpose: Constants of the multiply, branch and skip execution unit.
// Assumes: Included by bare name; definitions only.
// Notes:   Opcode patterns are casez patterns on the 16-bit instruction word.
`ifndef MBS_MAP_SVH
`define MBS_MAP_SVH
// ==========================================================================
// APB register offsets (byte addresses, 12-bit paddr; the GPR window as its paddr[11:7] value)
`define MBS_OFS_CTRL        12'h000
`define MBS_OFS_STAT        12'h004
`define MBS_OFS_PC          12'h008
`define MBS_OFS_FLAGS       12'h00C
`define MBS_OFS_EXTHI       12'h010
`define MBS_GPR_WIN         5'h01
// ==========================================================================
// Field positions and reset values
`define MBS_CTRL_RUN        0
`define MBS_STAT_BUSY       0
`define MBS_STAT_SP_LSB     8
`define MBS_RST_PC          32'h0000_0000
`define MBS_RST_FLAGS       8'h00
`define MBS_RST_EXTHI       8'h00
`define MBS_FL_T            6
`define MBS_FL_H            5
`define MBS_FL_S            4
`define MBS_FL_V            3
`define MBS_FL_N            2
`define MBS_FL_Z            1
`define MBS_FL_C            0
// ==========================================================================
// Opcode patterns
`define MBS_OP_MUL          16'b1001_11??_????_????
`define MBS_OP_PRODUCT_SIGNED         16'b0000_0010_????_????
`define MBS_OP_PRODUCT_MIXED_SIGN_GRP    16'b0000_0011_????_????
`define MBS_OP_RELATIVE_GOTO         16'b1100_????_????_????
`define MBS_OP_RELATIVE_SUBROUTINE_INVOKE        16'b1101_????_????_????
`define MBS_OP_POINTER_GOTO         16'b1001_0100_0000_1001
`define MBS_OP_EXTENDED_POINTER_GOTO        16'b1001_0100_0001_1001
`define MBS_OP_POINTER_SUBROUTINE_INVOKE        16'b1001_0101_0000_1001
`define MBS_OP_EXTENDED_POINTER_INVOKE       16'b1001_0101_0001_1001
`define MBS_OP_JMP          16'b1001_010?_????_110?
`define MBS_OP_CALL         16'b1001_010?_????_111?
`define MBS_OP_RET          16'b1001_0101_0000_1000
`define MBS_OP_INTERRUPT_EXIT         16'b1001_0101_0001_1000
`define MBS_OP_EQUAL_SKIP_COMPARE         16'b0001_00??_????_????
`define MBS_OP_CP           16'b0001_01??_????_????
`define MBS_OP_CPC          16'b0000_01??_????_????
`define MBS_OP_CPI          16'b0011_????_????_????
`define MBS_OP_SKIP_REG     16'b1111_11??_????_0???
`define MBS_OP_SKIP_IO      16'b1001_10?1_????_????
`define MBS_OP_BRANCH       16'b1111_0???_????_????
// ==========================================================================
// Cycle counts
`define MBS_CYC_MUL         2
`define MBS_CYC_GOTO        2
`define MBS_CYC_GOTO_ABS    3
`define MBS_CYC_INVOKE      4
`define MBS_CYC_INVOKE_ABS  5
`define MBS_CYC_EXIT        5
`define MBS_CYC_BR_TAKEN    2
`endif

// >>> hw/mbs_mul.sv
// Purpose: 8x8 multiplier with signed, mixed and fractional forms.
// Assumes: Operands already selected by the sequencer.
// Notes:   Purely combinational; the sequencer spends the second cycle.
`timescale 1ns/1ps
`default_nettype none
module mbs_mul (
   input  wire logic        [7:0]  op_a,
   input  wire logic        [7:0]  op_b,
   input  wire logic               a_signed,
   input  wire logic               b_signed,
   input  wire logic               frac,
   output logic             [15:0] result,
   output logic                    carry,
   output logic                    zero
);
   logic signed [8:0]  ext_a;
   logic signed [8:0]  ext_b;
   logic signed [17:0] full;

   // ========================================================================
   // Product
   assign ext_a  = $signed({a_signed & op_a[7], op_a});
   assign ext_b  = $signed({b_signed & op_b[7], op_b});
   assign full   = ext_a * ext_b;
   // Carry is taken from bit 15 before the fractional shift drops it
   assign carry  = full[15];
   assign result = frac ? {full[14:0], 1'b0} : full[15:0];
   assign zero   = (result == 16'h0000);
endmodule
`default_nettype wire

// >>> hw/mbs_pkg.sv
// Purpose: Types of the multiply, branch and skip execution unit.
// Assumes: Nothing.
// Notes:   Used as mbs_pkg::name, never imported.
`default_nettype none
package mbs_pkg;
   // =======================================================================
   // Sequencer states
   typedef enum logic [2:0] {
      mbs_st_idle,
      mbs_st_exec,
      mbs_st_word2,
      mbs_st_skipchk,
      mbs_st_wait
   } mbs_state_t;
endpackage
`default_nettype wire

// >>> tb/mbs_exec_props.sv
// Purpose: Port-level properties of the execution unit.
// Assumes: The program of mbs_imem (goto-self and I/O skip words).
// Notes:   Bound into every mbs_exec instance.
`timescale 1ns/1ps
`default_nettype none
module mbs_exec_props #(
   parameter int PC_W    = 22,
   parameter int STACK_D = 16
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic             pready,
   input wire logic [31:0]      prdata,
   input wire logic             pslverr,
   input wire logic [15:0]      imem_data,
   input wire logic [PC_W-1:0]  imem_addr,
   input wire logic [255:0]     io_low_bits,
   input wire logic             foreign_op,
   input wire logic [15:0]      foreign_word
);
   // ======================================================================
   // Sequences and properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   sequence s_skip_io;
      imem_data == 16'h9B00 && io_low_bits[0] ##1 imem_addr == $past(imem_addr) + 1;
   endsequence
   chk_ready_next: assert property (s_setup |=> pready) else $error("pready late");
   chk_ready_access: assert property (pready |-> s_access) else $error("pready stray");
   chk_ready_single: assert property (pready |=> !pready) else $error("pready long");
   chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr stray");
   chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("prdata on write");
   chk_foreign_pass: assert property (foreign_op |-> foreign_word == $past(imem_data)
      && imem_addr == $past(imem_addr) + 1) else $error("foreign op wrong");
   chk_reset_pc: assert property ($rose(presetn) |-> imem_addr == '0 && !foreign_op)
      else $error("reset state wrong");
   chk_goto_self:
      assert property (imem_data == 16'hCFFF && !psel |=> $stable(imem_addr))
      else $error("goto");
   chk_skip_io:
      assert property (s_skip_io |=> !foreign_op) else $error("io skip missed");
endmodule
bind mbs_exec mbs_exec_props #(.PC_W(PC_W), .STACK_D(STACK_D)) u_props (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .imem_data,
   .imem_addr, .io_low_bits, .foreign_op, .foreign_word);
`default_nettype wire

// >>> tb/mbs_exec_tb.sv
// Purpose: Self-checking bench of the execution unit.
// Assumes: Program in mbs_imem; the APB task waits for pready.
// Notes:   Expected results queue up; monitors compare at falling edges.
`timescale 1ns/1ps
`default_nettype none
module mbs_exec_tb;
   localparam int PC_W = 22;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [11:0]       paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [15:0]       imem_data;
   logic [15:0]       foreign_word;
   logic [PC_W-1:0]   imem_addr;
   logic [255:0]      io_low_bits;
   logic              foreign_op;
   int                fails;
   int                comparisons;
   integer            seed;
   logic [7:0]        a;
   logic [15:0]       prod;
   logic [32:0]       aq [$];
   logic [15:0]       fq [$];
   // ======================================================================
   // Clock, design and memory
   initial pclk = 1'b0;
   always #10 pclk = ~pclk;
   mbs_exec #(.PC_W(PC_W), .STACK_D(16)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .imem_data, .imem_addr, .io_low_bits,
      .foreign_op, .foreign_word);
   mbs_imem #(.PC_W(PC_W)) u_mem (.addr(imem_addr), .data(imem_data));
   // ======================================================================
   // Tasks
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                      input logic [32:0] e);
      aq.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Held until pready is seen high at a rising edge, then released
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic finish_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ======================================================================
   // Monitors
   always @(negedge pclk) begin
      if (psel && penable && pready === 1'b1) chk({pslverr, prdata}, aq.pop_front());
      if (foreign_op === 1'b1) chk({17'h0, foreign_word}, {17'h0, fq.pop_front()});
   end
   initial begin
      repeat (3000) @(posedge pclk);
      fails++;
      finish_test();
   end
   // ======================================================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      io_low_bits = '0;
      seed = 32'h5EBC;
      a = 8'($random(seed));
      prod = a * a;
      // Words 3, 4 lie under the branch, word 6 under the skip
      fq.push_back(16'h0189);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      io_low_bits <= {8{$random(seed)}} | 256'h1;
      apb(1'b0, 12'h00C, 32'h0, 33'h0);
      apb(1'b0, 12'h008, 32'h0, 33'h0);
      apb(1'b0, 12'h002, 32'h0, {1'b1, 32'h0});
      apb(1'b0, 12'h040, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 12'h004, 32'h1, {1'b1, 32'h0});
      apb(1'b1, 12'h0C0, {24'h0, a}, 33'h0);
      apb(1'b1, 12'h0C4, {24'h0, a}, 33'h0);
      $display("test register access done");
      apb(1'b1, 12'h000, 32'h1, 33'h0);
      for (int i = 0; i < 200 && fq.size() > 0; i++) @(posedge pclk);
      apb(1'b1, 12'h00C, 32'hFF, {1'b1, 32'h0});
      apb(1'b1, 12'h000, 32'h0, 33'h0);
      // The goto-self loop reaches a boundary every two cycles
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0, 33'h0);
      apb(1'b0, 12'h080, 32'h0, {25'h0, prod[7:0]});
      apb(1'b0, 12'h084, 32'h0, {25'h0, prod[15:8]});
      apb(1'b0, 12'h00C, 32'h0, 33'h2);
      apb(1'b0, 12'h008, 32'h0, 33'h8);
      $display("test program run done");
      // Second run from word 9: a fractional product, then a goto-self
      apb(1'b1, 12'h008, 32'h9, 33'h0);
      apb(1'b1, 12'h000, 32'h1, 33'h0);
      repeat (10) @(posedge pclk);
      apb(1'b1, 12'h000, 32'h0, 33'h0);
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h080, 32'h0, {25'h0, prod[6:0], 1'b0});
      apb(1'b0, 12'h084, 32'h0, {25'h0, prod[14:7]});
      apb(1'b0, 12'h00C, 32'h0, {31'h0, prod[14:0] == 15'h0000, prod[15]});
      apb(1'b0, 12'h008, 32'h0, 33'hA);
      $display("test fraction run done");
      finish_test();
   end
endmodule
`default_nettype wire

// >>> tb/mbs_imem.sv
// Purpose: Program memory model holding the test program.
// Assumes: Answers in the same cycle as the address.
// Notes:   Unused array words hold a goto-self so a stray fetch to them stays put.
`timescale 1ns/1ps
`default_nettype none
module mbs_imem #(
   parameter int PC_W = 22
) (
   input  wire logic [PC_W-1:0] addr,
   output logic      [15:0]     data
);
   logic [15:0] mem [0:15];
   initial begin
      mem = '{0: 16'h9F01, 1: 16'h1701, 2: 16'hF011, 3: 16'h0111, 4: 16'h0122,
              5: 16'h9B00, 6: 16'h0123, 7: 16'h0189, 8: 16'hCFFF,
              9: 16'h0309, default: 16'hCFFF};
   end
   // Beyond the array the word changes with the address, never a stale value
   assign data = (addr < 16) ? mem[addr[3:0]] : ~addr[15:0];
endmodule
`default_nettype wire
